// ==== vcp_core.sv ====
// Voice capture path: register bank, PDM clock, filters, gain, encoder
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "vcp_consts.svh"
module vcp_core (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic pdm_clk_o,
   input wire logic pdm_data_i,
   input wire logic [11:0] analog_microphone_data,
   input wire logic analog_microphone_valid,
   output logic smp_valid_o,
   output logic [15:0] smp_data_o
);
   vcp_pkg::vcp_st_t st_r, st_nxt;
   vcp_pcm_if pi();

   logic run, dmic, stereo_side_select, log_law_select, bw, plry;
   logic [1:0] dc_blocker_width, rsel;
   logic [6:0] gcode, gqr;
   vcp_pkg::vcp_enc_t enc;
   logic tick, in_vld, dv, cb;
   logic [15:0] a_sum;
   logic [5:0] div;
   logic signed [15:0] in_x, d_x, n_y, g_y;
   logic signed [16:0] ldif, ndif;
   logic signed [25:0] ny_n;
   logic signed [28:0] prod;
   logic signed [35:0] gprod;
   logic [2:0] ch;
   logic [11:0] step_n;
   logic [7:0] hc_r;
   logic [5:0] ic_r;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic signed [15:0] sat16(
      input logic signed [35:0] v);
      if (v > 36'sh7FFF) begin
         return 16'sh7FFF;
      end
      if (v < -36'sh8000) begin
         return 16'sh8000;
      end
      return 16'(v);
   endfunction

   function automatic logic signed [11:0] analog_microphone_lin(
      input logic [11:0] d, input logic p);
      logic signed [12:0] v;
      v = $signed({1'b0, d}) - 13'sh0800;
      if (p) begin
         v = -v;
      end
      return (v > 13'sh07FF) ? 12'sh7FF : 12'(v);
   endfunction

   // Splits the gain code into 6 dB octave and half-dB step
   function automatic logic [6:0] gain_qr(input logic [6:0] c);
      logic [6:0] e;
      logic [2:0] q;
      e = ((c > `VCP_GAIN_MAX) ? `VCP_GAIN_MAX : c) + 7'h08;
      q = 3'h0;
      for (int j = 1; j < 8; j++) begin
         if (e >= 7'(`VCP_GAIN_STEPS * j)) begin
            q = 3'(j);
         end
      end
      return {q, 4'(e - 7'(`VCP_GAIN_STEPS * q))};
   endfunction

   function automatic logic [11:0] gain_mant(input logic [3:0] r);
      unique case (r)
         4'h0: return 12'h400;
         4'h1: return 12'h43D;
         4'h2: return 12'h47D;
         4'h3: return 12'h4C1;
         4'h4: return 12'h509;
         4'h5: return 12'h556;
         4'h6: return 12'h5A6;
         4'h7: return 12'h5FC;
         4'h8: return 12'h657;
         4'h9: return 12'h6B7;
         4'hA: return 12'h71D;
         4'hB: return 12'h789;
         default: return 12'h400;
      endcase
   endfunction

   function automatic logic [7:0] mulaw(input logic signed [15:0] x);
      logic signed [15:0] v;
      logic [13:0] m;
      logic [2:0] sg;
      v = x >>> 2;
      m = x[15] ? 14'(-v) : 14'(v);
      if (m > 14'h1FDE) begin
         m = 14'h1FDE;
      end
      m = m + 14'h0021;
      sg = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (m[i + 5]) begin
            sg = 3'(i);
         end
      end
      return ~{x[15], sg, 4'(m >> ({1'b0, sg} + 4'h1))};
   endfunction

   function automatic logic [7:0] alaw(input logic signed [15:0] x);
      logic signed [15:0] v;
      logic [11:0] m;
      logic [2:0] sg;
      logic [3:0] mn;
      v = x >>> 3;
      m = x[15] ? 12'(-v - 16'sh0001) : 12'(v);
      sg = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (m[i + 4]) begin
            sg = 3'(i);
         end
      end
      mn = (sg == 3'h0) ? 4'(m >> 1) : 4'(m >> sg);
      return {1'b0, sg, mn} ^ (x[15] ? 8'h55 : 8'hD5);
   endfunction

   // Log PCM is pinned to 8 ksps and CVSD to 64 ksps
   function automatic logic [5:0] dec_div(
      input vcp_pkg::vcp_enc_t e, input logic [1:0] r);
      if (e == vcp_pkg::VCP_ENC_CVSD) begin
         return 6'(`VCP_DEC_BASE);
      end
      if (e == vcp_pkg::VCP_ENC_BYP) begin
         return 6'(`VCP_DEC_BASE << r);
      end
      return 6'(`VCP_DEC_PCM);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   assign run = st_r.enable;
   assign dmic = st_r.cfg[`VCP_F_MIC];
   assign plry = st_r.cfg[`VCP_F_PLRY];
   assign dc_blocker_width = st_r.cfg[`VCP_F_NOTCH +: 2];
   assign stereo_side_select = st_r.cfg[`VCP_F_SIDE];
   assign log_law_select = st_r.cfg[`VCP_F_LAW];
   assign bw = st_r.cfg[`VCP_F_BW];
   assign rsel = st_r.cfg[`VCP_F_RATE +: 2];
   assign enc = vcp_pkg::vcp_enc_t'(st_r.cfg[`VCP_F_ENC +: 2]);
   assign gcode = st_r.cfg[`VCP_F_GAIN +: 7];
   assign gqr = gain_qr(gcode);
   assign div = dec_div(enc, rsel);

   // The whole chain settles in one cycle per sample; at 320 ksps there
   // are over 600 clocks per sample, so depth was traded for area
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = 32'h0000_0000;
      st_nxt.ovld = 1'b0;
      st_nxt.bvld = 1'b0;
      tick = 1'b0;
      a_sum = 16'(st_r.acc) + 16'(`VCP_ACC_INC);
      ldif = '0;
      ndif = '0;
      prod = '0;
      ny_n = '0;
      dv = 1'b0;
      cb = 1'b0;
      ch = 3'h0;
      step_n = st_r.step;
      if (reg_wr && reg_addr == `VCP_OFF_ENABLE) begin
         st_nxt.enable = reg_wdata[0];
      end
      if (reg_wr && reg_addr == `VCP_OFF_CFG) begin
         st_nxt.cfg = reg_wdata & `VCP_CFG_MASK;
      end
      if (reg_rd) begin
         case (reg_addr)
            `VCP_OFF_ENABLE: st_nxt.rdata = {31'h0, st_r.enable};
            `VCP_OFF_CFG: st_nxt.rdata = st_r.cfg;
            `VCP_OFF_LAST: st_nxt.rdata = {16'h0000, st_r.last};
            default: st_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // Fractional divider: edges 78 clocks apart, every eighth one 79
      if (run && dmic) begin
         tick = a_sum >= 16'(`VCP_ACC_MOD);
         st_nxt.acc = tick ? 15'(a_sum - 16'(`VCP_ACC_MOD)) : 15'(a_sum);
         if (tick) begin
            st_nxt.pclk = ~st_r.pclk;
            if (st_r.pclk == stereo_side_select) begin
               st_nxt.bvld = 1'b1;
               st_nxt.bval = pdm_data_i;
            end
         end
      end else begin
         st_nxt.acc = '0;
         st_nxt.pclk = 1'b0;
      end
      // Source select
      in_vld = run && (dmic ? pi.pcm_vld : analog_microphone_valid);
      in_x = dmic ? {pi.pcm, 4'h0} :
         {analog_microphone_lin(analog_microphone_data, plry), 4'h0};
      // Low-pass before decimation, 8 kHz or 4 kHz corner
      if (in_vld) begin
         ldif = 17'(in_x) - 17'(st_r.lp);
         st_nxt.lp = st_r.lp + 16'(ldif >>> (bw ? 4 : 3));
         if (st_r.dcnt >= div - 6'h01) begin
            st_nxt.dcnt = 6'h00;
            dv = 1'b1;
         end else begin
            st_nxt.dcnt = st_r.dcnt + 6'h01;
         end
      end
      d_x = st_nxt.lp;
      // DC notch, y(n) = x(n) - x(n-1) + y(n-1) * (1 - k / 2^14)
      ndif = 17'(d_x) - 17'(st_r.nx);
      prod = st_r.ny * $signed({1'b0, dc_blocker_width});
      ny_n = 26'($signed({ndif, 8'h00})) + st_r.ny - 26'(prod >>> 14);
      n_y = (dc_blocker_width == 2'h0) ? d_x :
         sat16(36'(ny_n >>> 8));
      // Gain, mantissa table times a power of two
      gprod = (36'(n_y) * $signed({1'b0, gain_mant(gqr[3:0])})) <<< gqr[6:4];
      g_y = sat16(gprod >>> 14);
      // CVSD delta with syllabic step adaption
      cb = g_y >= st_r.est;
      ch = {st_r.hist[1:0], cb};
      if (ch == 3'h7 || ch == 3'h0) begin
         step_n = (st_r.step < `VCP_CVSD_MAX - `VCP_CVSD_INC) ?
            st_r.step + `VCP_CVSD_INC : `VCP_CVSD_MAX;
      end else begin
         step_n = (st_r.step > `VCP_CVSD_MIN + `VCP_CVSD_DEC) ?
            st_r.step - `VCP_CVSD_DEC : `VCP_CVSD_MIN;
      end
      if (dv) begin
         st_nxt.nx = d_x;
         st_nxt.ny = ny_n;
         st_nxt.ovld = 1'b1;
         unique case (enc)
            vcp_pkg::VCP_ENC_ALAW, vcp_pkg::VCP_ENC_ULAW: begin
               st_nxt.odata = {8'h00, (enc == vcp_pkg::VCP_ENC_ALAW ||
                  log_law_select) ? alaw(g_y) : mulaw(g_y)};
            end
            vcp_pkg::VCP_ENC_CVSD: begin
               st_nxt.hist = ch;
               st_nxt.step = step_n;
               st_nxt.est = sat16(cb ? 36'(st_r.est) + 36'(step_n) :
                  36'(st_r.est) - 36'(step_n));
               st_nxt.odata = {15'h0000, cb};
            end
            vcp_pkg::VCP_ENC_BYP: begin
               st_nxt.odata = g_y;
            end
         endcase
         st_nxt.last = st_nxt.odata;
      end
      // Idle core holds its filters cleared so a restart is clean
      if (!run) begin
         st_nxt.lp = '0;
         st_nxt.dcnt = '0;
         st_nxt.nx = '0;
         st_nxt.ny = '0;
         st_nxt.est = '0;
         st_nxt.hist = '0;
         st_nxt.step = `VCP_CVSD_MIN;
         st_nxt.ovld = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.cfg <= `VCP_CFG_RST;
         st_r.step <= `VCP_CVSD_MIN;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pi.bit_vld = st_r.bvld;
   assign pi.bit_val = st_r.bval;
   assign pi.clr = !run || !dmic;
   assign reg_rdata = st_r.rdata;
   assign pdm_clk_o = st_r.pclk;
   assign smp_valid_o = st_r.ovld;
   assign smp_data_o = st_r.odata;

   vcp_cic u_cic (
      .clk(clk),
      .sys_rst(sys_rst),
      .pi(pi)
   );

   ////////////////////////////////////////////////////////////////////////
   // Spacing counters watched only by the checks below
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hc_r <= 8'h00;
         ic_r <= 6'h00;
      end else begin
         hc_r <= (!(run && dmic) || tick) ? 8'h00 : hc_r + 8'h01;
         if (!run) begin
            ic_r <= 6'h00;
         end else if (in_vld) begin
            ic_r <= dv ? 6'h00 : ic_r + 6'h01;
         end
      end
   end

   default clocking cb_clk @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_idle_quiet: assert property (
      !run |=> !smp_valid_o && !pdm_clk_o)
      else $error("idle core produced activity");
   a_gain_unity: assert property (
      dv && gcode == `VCP_GAIN_UNITY |-> g_y == n_y)
      else $error("unity gain changed the sample");
   a_gain_six: assert property (
      dv && gcode == 7'h34 && n_y < 16'sh3E80 && n_y > -16'sh3E80
      |-> g_y == 16'(n_y <<< 1))
      else $error("plus 6 dB gain not doubling");
   a_enc_bypass: assert property (
      dv && enc == vcp_pkg::VCP_ENC_BYP |=> smp_valid_o &&
      smp_data_o == $past(g_y))
      else $error("bypass output differs from gain output");
   a_cvsd_bit: assert property (
      dv && enc == vcp_pkg::VCP_ENC_CVSD |=> smp_data_o[15:1] == 15'h0)
      else $error("CVSD output wider than one bit");
   a_rate_gap: assert property (
      dv && enc == vcp_pkg::VCP_ENC_BYP
      |-> ic_r == 6'(`VCP_DEC_BASE << rsel) - 6'h01)
      else $error("output rate does not follow rate field");
   a_law_pick: assert property (
      dv && enc == vcp_pkg::VCP_ENC_ULAW && log_law_select
      |=> smp_data_o == {8'h00, alaw($past(g_y))})
      else $error("law select bit ignored");
   a_notch_byp: assert property (
      dc_blocker_width == 2'h0 |-> n_y == d_x)
      else $error("notch not bypassed");
   a_pdm_gap: assert property (
      tick |-> hc_r == 8'h4D || hc_r == 8'h4E)
      else $error("PDM clock edge spacing wrong");
   a_side_edge: assert property (
      st_r.bvld |-> pdm_clk_o == !stereo_side_select)
      else $error("wrong PDM edge captured");
   a_src_sel: assert property (
      run && !dmic |-> in_vld == analog_microphone_valid && !pi.pcm_vld)
      else $error("digital path active in analog mode");
   a_pcm_rate: assert property (
      dv && (enc == vcp_pkg::VCP_ENC_ALAW || enc == vcp_pkg::VCP_ENC_ULAW)
      |-> ic_r == 6'(`VCP_DEC_PCM - 1))
      else $error("log PCM not at 8 ksps");

   c_alaw_out: cover property (dv && enc == vcp_pkg::VCP_ENC_ALAW);
   c_cvsd_out: cover property (dv && enc == vcp_pkg::VCP_ENC_CVSD);
   c_right_side: cover property (st_r.bvld && stereo_side_select);
   c_slow_rate: cover property (dv && rsel == 2'h3);
endmodule

// ==== vcp_consts.svh ====
// Constants for the voice capture path: offsets, fields, resets, timing
// Notes on behaviour
// - Core runs only while enable bit 0 is set; idle after reset.
// - Gain is (code minus 40) times 0.5 dB, capped at code 80, code in bits 22:16, reset 40.
// - Encoder field 13:12: A-law, mu-law, CVSD, bypass; reset value 2.
// - Rate field 9:8 gives 64, 32, 16 or 8 ksps in bypass; reset 0.
// - For log PCM, bit 6 high or encoder code 0 picks A-law; bit 6 low with code 1 picks mu-law.
// - Notch field 3:2 zero bypasses; else first-order IIR high-pass; reset 1.
// - PDM line sampled at 1.28 MHz; left on rising, right on falling.
// - Input is one analog microphone or a left/right digital pair.
// - Log PCM and CVSD output streams run at 64 kbit/s.
// - Source bit 0 low takes analog path, high takes digital path.
// - CIC turns 1-bit PDM into 12-bit PCM, 1.28 MHz down to 320 kHz.
`ifndef VCP_CONSTS_SVH
`define VCP_CONSTS_SVH
`define VCP_OFF_ENABLE 8'h00
`define VCP_OFF_SPARE 8'h08
`define VCP_OFF_CFG 8'h0C
`define VCP_OFF_LAST 8'h20
`define VCP_CFG_RST 32'h0028_2004
`define VCP_CFG_MASK 32'h007F_33EF
`define VCP_F_MIC 0
`define VCP_F_PLRY 1
`define VCP_F_NOTCH 2
`define VCP_F_SIDE 5
`define VCP_F_LAW 6
`define VCP_F_BW 7
`define VCP_F_RATE 8
`define VCP_F_ENC 12
`define VCP_F_GAIN 16
`define VCP_GAIN_UNITY 7'h28
`define VCP_GAIN_MAX 7'h50
`define VCP_GAIN_STEPS 12
`define VCP_CLK_HZ 200000000
`define VCP_PDM_HZ 1280000
`define VCP_ACC_MOD (`VCP_CLK_HZ / 10000)
`define VCP_ACC_INC (2 * `VCP_PDM_HZ / 10000)
`define VCP_CIC_R 4
`define VCP_DEC_BASE 5
`define VCP_DEC_PCM 40
`define VCP_CVSD_MIN 12'h010
`define VCP_CVSD_MAX 12'h500
`define VCP_CVSD_INC 12'h040
`define VCP_CVSD_DEC 12'h008
`endif

// ==== vcp_pkg.sv ====
// Types shared by the voice capture path modules
package vcp_pkg;
   typedef enum logic [1:0] {VCP_ENC_ALAW, VCP_ENC_ULAW, VCP_ENC_CVSD,
      VCP_ENC_BYP} vcp_enc_t;
   typedef struct packed {
      logic signed [9:0] i1, i2, i3, c1, c2, c3;
      logic [1:0] ph;
      logic vld;
      logic signed [11:0] pcm;
   } vcp_cic_st_t;
   typedef struct packed {
      logic enable;
      logic [31:0] cfg, rdata;
      logic [14:0] acc;
      logic pclk, bvld, bval;
      logic [5:0] dcnt;
      logic signed [15:0] lp, nx, est;
      logic signed [25:0] ny;
      logic [11:0] step;
      logic [2:0] hist;
      logic ovld;
      logic [15:0] odata, last;
   } vcp_st_t;
endpackage

// ==== vcp_pcm_if.sv ====
// Bit strobes to the decimator and PCM samples back
`timescale 1ns/1ps
interface vcp_pcm_if;
   logic bit_vld;
   logic bit_val;
   logic clr;
   logic pcm_vld;
   logic signed [11:0] pcm;
   modport core (output bit_vld, bit_val, clr, input pcm_vld, pcm);
   modport dec (input bit_vld, bit_val, clr, output pcm_vld, pcm);
endinterface

// ==== vcp_cic.sv ====
// Third-order CIC decimator for the digital microphone stream
`timescale 1ns/1ps
`include "vcp_consts.svh"
module vcp_cic (
   input wire logic clk,
   input wire logic sys_rst,
   vcp_pcm_if.dec pi
);
   vcp_pkg::vcp_cic_st_t st_r, st_nxt;
   logic signed [9:0] x, d0, d1, d2, y;
   logic [2:0] bc_r;

   // Integrators wrap on purpose; the comb stage undoes the wrap
   always_comb begin
      st_nxt = st_r;
      st_nxt.vld = 1'b0;
      x = pi.bit_val ? 10'sh001 : -10'sh001;
      d0 = '0;
      d1 = '0;
      d2 = '0;
      y = '0;
      if (pi.clr) begin
         st_nxt = '0;
      end else if (pi.bit_vld) begin
         st_nxt.i1 = st_r.i1 + x;
         st_nxt.i2 = st_r.i2 + st_nxt.i1;
         st_nxt.i3 = st_r.i3 + st_nxt.i2;
         st_nxt.ph = st_r.ph + 2'h1;
         if (st_r.ph == 2'(`VCP_CIC_R - 1)) begin
            d0 = st_nxt.i3;
            d1 = d0 - st_r.c1;
            d2 = d1 - st_r.c2;
            y = d2 - st_r.c3;
            st_nxt.c1 = d0;
            st_nxt.c2 = d1;
            st_nxt.c3 = d2;
            // Full scale is 64; scale to 12 bits and clip the top code
            st_nxt.pcm = (y > 10'sh03F) ? 12'sh7FF : {y[6:0], 5'h00};
            st_nxt.vld = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pi.pcm_vld = st_r.vld;
   assign pi.pcm = st_r.pcm;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bc_r <= 3'h0;
      end else if (pi.clr) begin
         bc_r <= 3'h0;
      end else if (st_r.vld) begin
         bc_r <= pi.bit_vld ? 3'h1 : 3'h0;
      end else if (pi.bit_vld) begin
         bc_r <= bc_r + 3'h1;
      end
   end

   a_cic_decim: assert property (
      @(posedge clk) disable iff (sys_rst) st_r.vld |-> bc_r == 3'h4)
      else $error("decimator output not after four bits");
endmodule

// ==== vcp_front_model.sv ====
// Partner model: SAR converter strobes and a left/right PDM microphone pair
`timescale 1ns/1ps
module vcp_front_model #(
   parameter int SAR_GAP = 2
) (
   input wire logic clk,
   input wire logic sar_run,
   input wire logic [11:0] sar_code,
   input wire logic pdm_clk,
   input wire logic left_bit,
   input wire logic right_bit,
   output logic [11:0] sar_data,
   output logic sar_valid,
   output logic pdm_data
);
   int gap_cnt = 0;
   int idle_cnt = 0;
   logic pdm_clk_d = 1'b0;
   initial begin
      sar_data = 12'h000;
      sar_valid = 1'b0;
      pdm_data = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // One analog microphone through the converter, fixed strobe spacing
   always @(posedge clk) begin
      if (sar_run && gap_cnt == SAR_GAP - 1) begin
         sar_valid <= 1'b1;
         sar_data <= sar_code;
         gap_cnt <= 0;
      end else begin
         sar_valid <= 1'b0;
         // Data outside a strobe is not held, so stale use shows up
         sar_data <= ~sar_data;
         gap_cnt <= sar_run ? gap_cnt + 1 : 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Left mic owns the line while the clock is low, right while high
   always @(posedge clk) begin
      pdm_clk_d <= pdm_clk;
      idle_cnt <= (pdm_clk != pdm_clk_d) ? 0 : idle_cnt + 1;
      if (idle_cnt > 200)
         pdm_data <= ~pdm_data; // Released line, no pull
      else
         pdm_data <= pdm_clk ? right_bit : left_bit;
   end
endmodule

// ==== tb_voice_capture_path.sv ====
// Self-checking bench for the voice capture path core
`timescale 1ns/1ps
module tb_voice_capture_path;
   localparam int GAP = 2;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic pdm_clk_o;
   logic pdm_data_i;
   logic [11:0] am_data;
   logic am_valid;
   logic smp_valid_o;
   logic [15:0] smp_data_o;
   logic sar_run = 1'b0;
   logic [11:0] sar_code = 12'h820;
   logic left_bit = 1'b1;
   logic right_bit = 1'b0;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   initial begin
      forever #2.5 clk = ~clk;
   end
   vcp_core vcp_core_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pdm_clk_o(pdm_clk_o), .pdm_data_i(pdm_data_i),
      .analog_microphone_data(am_data), .analog_microphone_valid(am_valid),
      .smp_valid_o(smp_valid_o), .smp_data_o(smp_data_o));
   vcp_front_model #(.SAR_GAP(GAP)) vcp_front_model_i (.clk(clk),
      .sar_run(sar_run), .sar_code(sar_code), .pdm_clk(pdm_clk_o),
      .left_bit(left_bit), .right_bit(right_bit), .sar_data(am_data),
      .sar_valid(am_valid), .pdm_data(pdm_data_i));
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("Checked %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Ceiling well above the roughly 32k cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         errors++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
      samples_checked++;
      // A value with unknown bits must not slip through as in range
      if (((got >= lo) && (got <= hi)) !== 1'b1) begin
         errors++;
         $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_smp(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (smp_valid_o !== 1'b1 && n < 20000);
      if (n >= 20000)
         chk(32'h0, 32'h1);
   endtask
   function automatic logic [31:0] cw(int g, int e, int r, int law, int sd,
      int nt, int src);
      return (32'(g) << 16) | (32'(e) << 12) | (32'(r) << 8) |
         (32'(law) << 6) | (32'(sd) << 5) | (32'(nt) << 2) | 32'(src);
   endfunction
   // Disabling first clears the filters, so each run starts clean
   task automatic start(input logic [31:0] c);
      wr(8'h00, 32'h0);
      wr(8'h0C, c);
      wr(8'h00, 32'h1);
   endtask
   task automatic skip(input int k);
      int n;
      repeat (k) wait_smp(n);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] d;
      rd(8'h00, d);
      chk(d, 32'h0);
      rd(8'h0C, d);
      chk(d, (32'd40 << 16) | (32'd2 << 12) | 32'd4);
      wr(8'h08, 32'hFFFF_FFFF);
      rd(8'h08, d);
      chk(d, 32'h0);
      rd(8'h04, d);
      chk(d, 32'h0);
      wr(8'h0C, 32'hFFFF_FFFF);
      rd(8'h0C, d);
      chk(d, 32'h007F_33EF);
      @(posedge clk);
      #1 chk(reg_rdata, 32'h0);
      wr(8'h00, 32'hFFFF_FFFF);
      rd(8'h00, d);
      chk(d, 32'h1);
      $display("test reset_and_registers done");
   endtask
   task automatic t_idle();
      int hi_cnt;
      int smp_cnt;
      sar_run <= 1'b1;
      wr(8'h00, 32'h0);
      wr(8'h0C, cw(40, 3, 0, 0, 0, 0, 1));
      hi_cnt = 0;
      smp_cnt = 0;
      repeat (400) begin
         @(posedge clk);
         #1 hi_cnt += pdm_clk_o;
         smp_cnt += smp_valid_o;
      end
      chk(hi_cnt + smp_cnt, 32'h0);
      start(cw(40, 3, 0, 0, 0, 0, 0));
      repeat (400) begin
         @(posedge clk);
         #1 hi_cnt += pdm_clk_o;
         smp_cnt += smp_valid_o;
      end
      chk(hi_cnt, 32'h0);
      chk_rng(smp_cnt, 1, 400);
      $display("test idle_and_analog done");
   endtask
   task automatic t_rates();
      int n;
      for (int r = 0; r < 4; r++) begin
         start(cw(40, 3, r, 0, 0, 0, 0));
         skip(1);
         wait_smp(n);
         chk(n, (5 << r) * GAP);
      end
      $display("test output_rates done");
   endtask
   task automatic t_enc();
      int n;
      logic [15:0] code [3];
      for (int k = 0; k < 3; k++) begin
         start(cw(40, k == 0 ? 0 : 1, 3, k == 1, 0, 0, 0));
         skip(6);
         wait_smp(n);
         chk(n, 40 * GAP);
         chk(smp_data_o[15:8], 8'h00);
         code[k] = smp_data_o;
      end
      chk(code[0], code[1]);
      chk(code[2] != code[1], 1'b1);
      start(cw(40, 2, 3, 0, 0, 0, 0));
      skip(2);
      wait_smp(n);
      chk(n, 5 * GAP);
      chk(smp_data_o[15:1], 15'h0000);
      $display("test encoders done");
   endtask
   task automatic t_gain();
      logic signed [15:0] lp;
      logic signed [15:0] ln;
      logic signed [15:0] lm;
      logic [31:0] d;
      lp = 16'sh0000;
      ln = 16'sh0000;
      lm = 16'sh0000;
      // Low-pass settling worked out step by step for a steady input
      repeat (400) lp = lp + ((16'sd512 - lp) >>> 3);
      repeat (400) ln = ln + ((16'sd512 - ln) >>> 4);
      repeat (400) lm = lm + ((-16'sd512 - lm) >>> 3);
      start(cw(40, 3, 0, 0, 0, 0, 0));
      skip(80);
      chk(smp_data_o, lp);
      rd(8'h20, d);
      chk(d, lp);
      wr(8'h0C, cw(52, 3, 0, 0, 0, 0, 0));
      skip(3);
      chk(smp_data_o, lp * 2);
      wr(8'h0C, cw(28, 3, 0, 0, 0, 0, 0));
      skip(3);
      chk(smp_data_o, lp >>> 1);
      // Narrow low-pass, then the analog input with inverted polarity
      start(cw(40, 3, 0, 0, 0, 0, 0) | 32'h0000_0080);
      skip(80);
      chk(smp_data_o, ln);
      start(cw(40, 3, 0, 0, 0, 0, 2));
      skip(80);
      chk(smp_data_o, $unsigned(lm));
      $display("test gain done");
   endtask
   task automatic t_notch();
      logic signed [15:0] a;
      logic signed [15:0] b;
      for (int nt = 0; nt < 4; nt += 3) begin
         start(cw(40, 3, 0, 0, 0, nt, 0));
         skip(60);
         a = smp_data_o;
         skip(500);
         b = smp_data_o;
         if (nt == 0)
            chk(b, a);
         else
            chk(b < a && b > 0, 1'b1);
      end
      $display("test dc_notch done");
   endtask
   task automatic t_digital();
      int n;
      int tg;
      logic p;
      start(cw(40, 3, 0, 0, 0, 0, 1));
      // Look after the edge has settled, not in its own time step
      while (pdm_clk_o !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      tg = 0;
      p = 1'b1;
      repeat (1563) begin
         @(posedge clk);
         #1 tg += (pdm_clk_o != p);
         p = pdm_clk_o;
      end
      chk_rng(tg, 19, 21);
      skip(2);
      wait_smp(n);
      chk_rng(n, 3123, 3127);
      chk(smp_data_o[15], 1'b0);
      start(cw(40, 3, 0, 0, 1, 0, 1));
      skip(2);
      chk(smp_data_o[15], 1'b1);
      $display("test digital_mics done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_idle();
      t_rates();
      t_enc();
      t_gain();
      t_notch();
      t_digital();
      final_report();
   end
endmodule
